// *** sss_pkg.sv ***
// sss_pkg: register map, field positions and reset values of the
// synchronous serial shift engine; shared by the engine and its bench.
package sss_pkg;
   // byte offsets on the register bus
   localparam logic [3:0] SSS_OFF_CTRL = 4'h0;
   localparam logic [3:0] SSS_OFF_STAT = 4'h4;
   localparam logic [3:0] SSS_OFF_TXB = 4'h8;
   localparam logic [3:0] SSS_OFF_RXB = 4'hC;
   // serial_control_reg fields
   localparam int SSS_CTRL_START = 0;
   localparam int SSS_CTRL_INHIBIT = 1;
   localparam int SSS_CTRL_ORDER = 2;
   localparam int SSS_CTRL_MODE_LO = 3;
   localparam int SSS_CTRL_CLK_LO = 5;
   // serial_status_reg fields
   localparam int SSS_STAT_BUSY = 0;
   localparam int SSS_STAT_PARTIAL = 1;
   localparam int SSS_STAT_TXE = 2;
   localparam int SSS_STAT_RXF = 3;
   localparam int SSS_STAT_TRANSMIT_UNDERRUN_FLAG = 4;
   localparam int SSS_STAT_RECEIVE_OVERRUN_FLAG = 5;
   // transfer_mode_field codes
   typedef enum logic [1:0] {
      SSS_MODE_TX = 2'b00,
      SSS_MODE_RX = 2'b01,
      SSS_MODE_DUPLEX = 2'b10,
      SSS_MODE_NONE = 2'b11
   } sss_mode_type;
   // clock select: all ones takes the clock from the pin
   localparam logic [2:0] SSS_CLK_EXTERNAL = 3'h7;
   // divide ratio is 2**exp of MCLK; code 0 is the slow rate
   localparam logic [3:0] SSS_DIV_EXP_SLOW = 4'hC;
   localparam logic [3:0] SSS_DIV_EXP_BASE = 4'h9;
   // reset values
   localparam logic [7:0] SSS_CTRL_RESET = 8'h00;
   localparam logic [7:0] SSS_BUF_RESET = 8'h00;
   localparam logic SSS_TXE_RESET = 1'b1;
   localparam logic [3:0] SSS_BITS_PER_BYTE = 4'h8;
endpackage : sss_pkg

// *** sss_shift_engine.sv ***
// sss_shift_engine: eight-bit synchronous serial shifter with an
// Avalon-MM register slave, internal or external serial clock.
// assumes MCLK at 200 MHz, synchronous RESET, pins from outside MCLK.
// How it works
// - drive data on falling, sample on rising
// - one order bit for both directions
// - order 0 msb first, 1 lsb first
// - mode 00 transmit, 01 receive
// - transmit buffer write clears empty flag
// - busy flag rises at next falling edge
// - partial flag high falls one to seven
// - empty flag at rise, mode 00 interrupt next fall
// - internal transmit waits for buffered byte
// - internal clock starts within one period
// - external first fall loads shift register
// - internal clock parks high, resumes on write
// - byte written in time goes back to back
// - external empty buffer sets transmit error
// - start cleared: finish byte, idle, data high
// - inhibit aborts, clears flags, buffers and start; other control bits take the written value
// - transmit error holds data high until inhibit or write 0
// - receive: copy byte, set full, interrupt
// - read clears full unless receive error set; internal clock waits for it
// - external overrun sets receive error, interrupt
// - mode 10 full duplex
// - clock select 111 external, else internal
// - write 0 clears error, start stop keeps it
`timescale 1ns/1ps
module sss_shift_engine
   import sss_pkg::*;
(
   // clock and reset
   input wire logic MCLK,
   input wire logic RESET,
   // avalon-mm slave
   input wire logic [3:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   // serial pins
   input wire logic SCK_I,
   output logic SCK_O,
   output logic SCK_OE,
   input wire logic SI_I,
   output logic SO_O,
   // serial_interrupt_request, one MCLK pulse
   output logic SIRQ_O
);
   logic wait_ff;
   logic [31:0] rdata_ff;
   logic [7:0] ctrl_ff;
   logic busy_ff, partial_ff, txe_ff, rxf_ff, transmit_underrun_flag_ff, receive_overrun_flag_ff;
   logic [7:0] txbuf_ff, rxbuf_ff, shreg_ff;
   logic [3:0] cnt_ff;
   logic load_pend_ff, irq_pend_ff, irq_ff, so_ff;
   logic sck_s1_ff, sck_s2_ff, sck_s3_ff, si_s1_ff, si_s2_ff;
   logic sck_int_ff, sck_oe_ff;
   logic [10:0] div_ff;
   logic take, wr_ctrl, wr_stat, wr_tx, rd_rx, do_inh;
   logic start, order, external, go, int_fall, int_rise, fall_ev, rise_ev;
   logic wants_tx, wants_rx, byte_end;
   logic [7:0] nxt_shreg;
   logic [3:0] div_exp;
   logic [10:0] half_last;
   sss_mode_type mode;

   // bus slave: waitrequest drops one cycle after a request
   assign take = (AVS_READ || AVS_WRITE) && !wait_ff;
   assign wr_ctrl = take && AVS_WRITE && AVS_ADDRESS == SSS_OFF_CTRL;
   assign wr_stat = take && AVS_WRITE && AVS_ADDRESS == SSS_OFF_STAT;
   assign wr_tx = take && AVS_WRITE && AVS_ADDRESS == SSS_OFF_TXB;
   assign rd_rx = take && AVS_READ && AVS_ADDRESS == SSS_OFF_RXB;
   assign do_inh = wr_ctrl && AVS_WRITEDATA[SSS_CTRL_INHIBIT];

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         wait_ff <= 1'b1;
      end else if ((AVS_READ || AVS_WRITE) && wait_ff) begin
         wait_ff <= 1'b0;
      end else begin
         wait_ff <= 1'b1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         rdata_ff <= 32'h0;
      end else if (AVS_READ && wait_ff) begin
         unique case (AVS_ADDRESS)
            SSS_OFF_CTRL: rdata_ff <= {24'h0, ctrl_ff};
            SSS_OFF_STAT: rdata_ff <= {26'h0, receive_overrun_flag_ff, transmit_underrun_flag_ff, rxf_ff, txe_ff,
                                       partial_ff, busy_ff};
            SSS_OFF_RXB: rdata_ff <= {24'h0, rxbuf_ff};
            default: rdata_ff <= 32'h0;
         endcase
      end
   end

   // control register; inhibit bit is a command and reads zero
   assign start = ctrl_ff[SSS_CTRL_START];
   assign order = ctrl_ff[SSS_CTRL_ORDER];
   assign mode = sss_mode_type'(ctrl_ff[SSS_CTRL_MODE_LO +: 2]);
   assign external = ctrl_ff[SSS_CTRL_CLK_LO +: 3] == SSS_CLK_EXTERNAL;

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         ctrl_ff <= SSS_CTRL_RESET;
      end else if (do_inh) begin
         ctrl_ff <= {AVS_WRITEDATA[7:2], 2'b00};
      end else if (wr_ctrl) begin
         ctrl_ff <= {AVS_WRITEDATA[7:2], 1'b0, AVS_WRITEDATA[SSS_CTRL_START]};
      end
   end

   // pin synchronisers
   always_ff @(posedge MCLK) begin
      if (RESET) begin
         sck_s1_ff <= 1'b1;
         sck_s2_ff <= 1'b1;
         sck_s3_ff <= 1'b1;
         si_s1_ff <= 1'b1;
         si_s2_ff <= 1'b1;
      end else begin
         sck_s1_ff <= SCK_I;
         sck_s2_ff <= sck_s1_ff;
         sck_s3_ff <= sck_s2_ff;
         si_s1_ff <= SI_I;
         si_s2_ff <= si_s1_ff;
      end
   end

   // byte may begin: mode needs, auto-wait on buffers
   assign wants_tx = mode == SSS_MODE_TX || mode == SSS_MODE_DUPLEX;
   assign wants_rx = mode == SSS_MODE_RX || mode == SSS_MODE_DUPLEX;
   assign go = start && !transmit_underrun_flag_ff && mode != SSS_MODE_NONE
               && !(wants_tx && txe_ff) && !(wants_rx && rxf_ff);

   // internal clock divider, idles high
   assign div_exp = ctrl_ff[SSS_CTRL_CLK_LO +: 3] == 3'h0 ? SSS_DIV_EXP_SLOW
                    : SSS_DIV_EXP_BASE - {1'b0, ctrl_ff[SSS_CTRL_CLK_LO +: 3]};
   assign half_last = 11'((12'h1 << (div_exp - 4'h1)) - 12'h1);
   assign int_fall = !external && sck_int_ff && div_ff == half_last
                     && (cnt_ff != 4'h0 || go);
   assign int_rise = !external && !sck_int_ff && div_ff == half_last;
   assign fall_ev = external ? (sck_s3_ff && !sck_s2_ff) : int_fall;
   assign rise_ev = external ? (!sck_s3_ff && sck_s2_ff) : int_rise;
   assign byte_end = rise_ev && cnt_ff == SSS_BITS_PER_BYTE;

   always_ff @(posedge MCLK) begin
      if (RESET || do_inh || external) begin
         div_ff <= 11'h0;
         sck_int_ff <= 1'b1;
      end else if (sck_int_ff && cnt_ff == 4'h0 && !go) begin
         div_ff <= 11'h0; // parked high
      end else if (div_ff == half_last) begin
         div_ff <= 11'h0;
         sck_int_ff <= !sck_int_ff; // first fall within one period
      end else begin
         div_ff <= div_ff + 11'h1;
      end
   end

   always_ff @(posedge MCLK) begin
      if (RESET) begin
         sck_oe_ff <= 1'b0;
      end else begin
         sck_oe_ff <= !external;
      end
   end

   // bit counter and partial flag
   always_ff @(posedge MCLK) begin
      if (RESET || do_inh) begin
         cnt_ff <= 4'h0;
         partial_ff <= 1'b0;
      end else if (fall_ev && cnt_ff == 4'h0 && start) begin
         cnt_ff <= 4'h1;
         partial_ff <= 1'b1;
      end else if (fall_ev && cnt_ff != 4'h0 && cnt_ff != SSS_BITS_PER_BYTE) begin
         cnt_ff <= cnt_ff + 4'h1;
         partial_ff <= cnt_ff != 4'h7; // low from eighth fall
      end else if (byte_end) begin
         cnt_ff <= 4'h0;
      end
   end

   // busy flag
   always_ff @(posedge MCLK) begin
      if (RESET || do_inh) begin
         busy_ff <= 1'b0;
      end else if (fall_ev && cnt_ff == 4'h0 && start) begin
         busy_ff <= 1'b1;
      end else if (cnt_ff == 4'h0 && !start) begin
         busy_ff <= 1'b0; // after the byte in progress
      end
   end

   // shift register: load at first fall, shift in at rise
   assign nxt_shreg = order ? {si_s2_ff, shreg_ff[7:1]} : {shreg_ff[6:0], si_s2_ff};

   always_ff @(posedge MCLK) begin
      if (RESET || do_inh) begin
         shreg_ff <= SSS_BUF_RESET;
      end else if (fall_ev && cnt_ff == 4'h0 && start && wants_tx && !txe_ff) begin
         shreg_ff <= txbuf_ff;
      end else if (rise_ev && cnt_ff != 4'h0) begin
         shreg_ff <= nxt_shreg;
      end
   end

   // serial data out changes on falling edges; forced high when stopped or in error
   always_ff @(posedge MCLK) begin
      if (RESET || do_inh) begin
         so_ff <= 1'b1;
      end else if (transmit_underrun_flag_ff || (fall_ev && cnt_ff == 4'h0 && wants_tx && txe_ff)) begin
         so_ff <= 1'b1;
      end else if (cnt_ff == 4'h0 && !start) begin
         so_ff <= 1'b1; // stopped: line back to high
      end else if (fall_ev && cnt_ff == 4'h0) begin
         so_ff <= !start || !wants_tx ? 1'b1
                  : (order ? txbuf_ff[0] : txbuf_ff[7]);
      end else if (fall_ev && cnt_ff != SSS_BITS_PER_BYTE) begin
         so_ff <= !wants_tx ? 1'b1 : (order ? shreg_ff[0] : shreg_ff[7]);
      end
   end

   // transmit buffer and empty flag
   always_ff @(posedge MCLK) begin
      if (RESET || do_inh) begin
         txbuf_ff <= SSS_BUF_RESET;
         txe_ff <= SSS_TXE_RESET;
         load_pend_ff <= 1'b0;
      end else begin
         if (wr_tx && txe_ff) begin
            txbuf_ff <= AVS_WRITEDATA[7:0];
         end
         if (fall_ev && cnt_ff == 4'h0 && start && wants_tx && !txe_ff) begin
            load_pend_ff <= 1'b1;
         end else if (rise_ev) begin
            load_pend_ff <= 1'b0;
         end
         if (rise_ev && load_pend_ff) begin
            txe_ff <= 1'b1;
         end else if (wr_tx) begin
            txe_ff <= 1'b0;
         end
      end
   end

   // error flags: hardware set wins over a write of zero
   always_ff @(posedge MCLK) begin
      if (RESET || do_inh) begin
         transmit_underrun_flag_ff <= 1'b0;
         receive_overrun_flag_ff <= 1'b0;
      end else begin
         if (external && fall_ev && cnt_ff == 4'h0 && start && wants_tx && txe_ff) begin
            transmit_underrun_flag_ff <= 1'b1;
         end else if (wr_stat && !AVS_WRITEDATA[SSS_STAT_TRANSMIT_UNDERRUN_FLAG]) begin
            transmit_underrun_flag_ff <= 1'b0;
         end
         if (external && byte_end && wants_rx && rxf_ff) begin
            receive_overrun_flag_ff <= 1'b1;
         end else if (wr_stat && !AVS_WRITEDATA[SSS_STAT_RECEIVE_OVERRUN_FLAG]) begin
            receive_overrun_flag_ff <= 1'b0;
         end
      end
   end

   // receive buffer and full flag; overrun leaves old byte
   always_ff @(posedge MCLK) begin
      if (RESET || do_inh) begin
         rxbuf_ff <= SSS_BUF_RESET;
         rxf_ff <= 1'b0;
      end else if (byte_end && wants_rx && !rxf_ff && !receive_overrun_flag_ff) begin
         rxbuf_ff <= nxt_shreg;
         rxf_ff <= 1'b1;
      end else if (rd_rx && !receive_overrun_flag_ff) begin
         rxf_ff <= 1'b0;
      end
   end

   // interrupt request: transmit events wait for the next fall
   always_ff @(posedge MCLK) begin
      if (RESET || do_inh) begin
         irq_pend_ff <= 1'b0;
         irq_ff <= 1'b0;
      end else begin
         irq_ff <= (fall_ev && irq_pend_ff)
                   || (byte_end && wants_rx && !receive_overrun_flag_ff);
         if (fall_ev && irq_pend_ff) begin
            irq_pend_ff <= 1'b0;
         end else if ((rise_ev && load_pend_ff && mode == SSS_MODE_TX)
                      || (!transmit_underrun_flag_ff && external && fall_ev && cnt_ff == 4'h0
                          && start && wants_tx && txe_ff)) begin
            irq_pend_ff <= 1'b1;
         end
      end
   end

   assign AVS_WAITREQUEST = wait_ff;
   assign AVS_READDATA = rdata_ff;
   assign SCK_O = sck_int_ff;
   assign SCK_OE = sck_oe_ff;
   assign SO_O = so_ff;
   assign SIRQ_O = irq_ff;

   default clocking dc @(posedge MCLK); endclocking
   default disable iff (RESET);

   rise_hold_a: assert property (rise_ev && !do_inh && !transmit_underrun_flag_ff |=> $stable(so_ff))
      else $error("serial data changed on a rising edge");
   msb_first_a: assert property (fall_ev && cnt_ff == 4'h0 && start && wants_tx && !txe_ff
         && !transmit_underrun_flag_ff && !order && !do_inh |=> so_ff == $past(txbuf_ff[7]))
      else $error("first bit is not bit 7 in msb order");
   txe_clear_a: assert property (wr_tx && txe_ff && !do_inh |=> !txe_ff)
      else $error("transmit write did not clear empty flag");
   partial_cnt_a: assert property (partial_ff == (cnt_ff >= 4'h1 && cnt_ff <= 4'h7))
      else $error("partial flag disagrees with bit count");
   park_high_a: assert property (!external && sck_int_ff && cnt_ff == 4'h0 && !go
         |=> sck_int_ff [*2])
      else $error("internal clock left park without a go");
   inhibit_all_a: assert property (do_inh |=> !start && !busy_ff && txe_ff && !rxf_ff
         && !transmit_underrun_flag_ff && !receive_overrun_flag_ff && cnt_ff == 4'h0)
      else $error("inhibit left state behind");
   err_high_a: assert property (transmit_underrun_flag_ff |-> so_ff)
      else $error("data out not high during transmit error");
   rx_done_a: assert property (byte_end && wants_rx && !rxf_ff && !receive_overrun_flag_ff && !do_inh
         |=> rxf_ff && irq_ff && rxbuf_ff == $past(nxt_shreg))
      else $error("received byte not delivered");
   err_keep_a: assert property (wr_stat && AVS_WRITEDATA[SSS_STAT_TRANSMIT_UNDERRUN_FLAG] && transmit_underrun_flag_ff
         && !do_inh |=> transmit_underrun_flag_ff)
      else $error("writing one cleared the error flag");
   bus_answer_a: assert property ((AVS_READ || AVS_WRITE) && wait_ff |=> !wait_ff ##1 wait_ff)
      else $error("waitrequest did not answer in one cycle");
   busy_set_a: assert property (fall_ev && cnt_ff == 4'h0 && start && !do_inh
         |=> busy_ff && partial_ff)
      else $error("busy or partial flag missed the first fall");
   lsb_first_a: assert property (fall_ev && cnt_ff == 4'h0 && start && wants_tx && !txe_ff
         && !transmit_underrun_flag_ff && order && !do_inh |=> so_ff == $past(txbuf_ff[0]))
      else $error("first bit is not bit 0 in lsb order");
   txe_set_a: assert property (rise_ev && load_pend_ff && !do_inh |=> txe_ff)
      else $error("empty flag not set at rise after load");
   tx_irq_a: assert property (fall_ev && irq_pend_ff && !do_inh |=> irq_ff)
      else $error("transmit interrupt missed its falling edge");
   tx_under_a: assert property (external && fall_ev && cnt_ff == 4'h0 && start
         && wants_tx && txe_ff && !do_inh |=> transmit_underrun_flag_ff && so_ff)
      else $error("underrun did not raise transmit error");
   rx_over_a: assert property (external && byte_end && wants_rx && rxf_ff && !rd_rx
         && !do_inh |=> receive_overrun_flag_ff && rxf_ff && rxbuf_ff == $past(rxbuf_ff))
      else $error("overrun did not raise receive error");
   rx_clear_a: assert property (rd_rx && !receive_overrun_flag_ff && !(byte_end && wants_rx) && !do_inh
         |=> !rxf_ff)
      else $error("receive read did not clear full flag");
   clk_drive_a: assert property (1'b1 |=> sck_oe_ff == !$past(external))
      else $error("clock pin drive disagrees with clock select");
   stop_idle_a: assert property (cnt_ff == 4'h0 && !start && !do_inh
         |=> !busy_ff && so_ff)
      else $error("stopped engine not idle with data high");
   wr_load_a: assert property (wr_tx && txe_ff && !do_inh
         |=> txbuf_ff == $past(AVS_WRITEDATA[7:0]))
      else $error("transmit buffer write not stored");

   tx_byte_c: cover property (rise_ev && load_pend_ff && mode == SSS_MODE_TX);
   rx_byte_c: cover property (byte_end && wants_rx && !rxf_ff);
   tx_under_c: cover property ($rose(transmit_underrun_flag_ff));
   back_back_c: cover property (byte_end ##[1:400] fall_ev && cnt_ff == 4'h0 && busy_ff);
   duplex_c: cover property (byte_end && mode == SSS_MODE_DUPLEX);
endmodule : sss_shift_engine

// *** sss_peer.sv ***
// sss_peer: external serial peer of the shift engine.
// assumes the bench feeds it the resolved clock pin level; its own clock
// runs only inside a frame, six MCLK per half period.
`timescale 1ns/1ps
module sss_peer (
   // clock
   input wire logic clk,
   // bench control
   input wire logic arm,
   input wire logic ext_go,
   input wire logic lsb,
   input wire logic [7:0] tx_byte,
   // serial pins
   input wire logic pin,
   input wire logic so,
   output logic sck_ext,
   output logic si,
   // observation
   output logic [4:0] bits,
   output logic [15:0] cap
);
   logic pin_d = 1'b1;
   logic [3:0] fcnt = 4'h0;
   logic [4:0] halves = 5'h00;
   logic [2:0] ph = 3'h0;
   initial begin
      sck_ext = 1'b1;
      si = 1'b1;
      bits = 5'h00;
      cap = 16'h0000;
   end
   // data: out on falling pin edge, captured on rising
   always @(posedge clk) begin
      pin_d <= pin;
      if (arm) begin
         fcnt <= 4'h0;
         bits <= 5'h00;
         si <= ~si;
      end else if (pin_d && !pin) begin
         si <= (fcnt < 4'h8) ? tx_byte[lsb ? fcnt[2:0] : 3'h7 - fcnt[2:0]] : ~si;
         fcnt <= fcnt + 4'h1;
      end else if (!pin_d && pin) begin
         cap <= {cap[14:0], so};
         bits <= bits + 5'h01;
      end
   end
   // eight pulses per frame, parked high outside it
   always @(posedge clk) begin
      if (ext_go) begin
         halves <= 5'h10;
         ph <= 3'h0;
      end else if (halves != 5'h00) begin
         ph <= (ph == 3'h5) ? 3'h0 : ph + 3'h1;
         if (ph == 3'h5) begin
            sck_ext <= ~sck_ext;
            halves <= halves - 5'h01;
         end
      end
   end
endmodule : sss_peer

// *** tb_top.sv ***
// tb_top: self-checking bench of the serial shift engine.
// assumes the engine's one-wait-cycle avalon slave and the sss_peer model.
`timescale 1ns/1ps
module tb_top;
   import sss_pkg::*;
   typedef struct packed {
      logic [2:0] ck;
      logic [1:0] md;
      logic ord;
      logic [7:0] tx;
      logic [7:0] rx;
   } sss_row_type;
   logic mclk, reset, rd, wr, arm, ext_go, lsb, waitreq, sck_o, sck_oe, sck_ext, si, so, sirq;
   logic [3:0] addr;
   logic [31:0] wdata, rdata;
   logic [7:0] txb;
   logic [4:0] bits;
   logic [15:0] cap;
   int err_count = 0;
   int checks_done = 0;
   int cyc = 0;
   int irq_n = 0;
   int base, t1;
   sss_row_type r;
   sss_row_type rows [8] = '{
      '{3'h6, 2'h0, 1'b0, 8'hA5, 8'h00}, '{3'h6, 2'h0, 1'b1, 8'h3C, 8'h00},
      '{3'h6, 2'h1, 1'b0, 8'h00, 8'h96}, '{3'h6, 2'h1, 1'b1, 8'h00, 8'h1E},
      '{3'h6, 2'h2, 1'b0, 8'hC3, 8'h5A}, '{3'h7, 2'h0, 1'b1, 8'h81, 8'h00},
      '{3'h7, 2'h1, 1'b0, 8'h00, 8'hE7}, '{3'h7, 2'h2, 1'b1, 8'hF0, 8'h0F}};
   wire logic pin = sck_oe ? sck_o : sck_ext;
   sss_shift_engine uut (.MCLK(mclk), .RESET(reset), .AVS_ADDRESS(addr), .AVS_READ(rd),
      .AVS_WRITE(wr), .AVS_WRITEDATA(wdata), .AVS_READDATA(rdata), .AVS_WAITREQUEST(waitreq),
      .SCK_I(pin), .SCK_O(sck_o), .SCK_OE(sck_oe), .SI_I(si), .SO_O(so), .SIRQ_O(sirq));
   sss_peer peer (.clk(mclk), .arm(arm), .ext_go(ext_go), .lsb(lsb), .tx_byte(txb), .pin(pin),
      .so(so), .sck_ext(sck_ext), .si(si), .bits(bits), .cap(cap));
   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end
   always @(posedge mclk) begin
      cyc <= cyc + 1;
      if (sirq === 1'b1) irq_n <= irq_n + 1;
      if (cyc == 40000) begin
         err_count++;
         end_sim();
      end
   end
   task automatic end_sim();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // hold the request until waitrequest is seen low at a falling edge
   task automatic bus(input logic we, input logic [3:0] a, input logic [7:0] d,
         output logic [31:0] q);
      logic w;
      int n;
      n = 0;
      @(posedge mclk);
      wr <= we;
      rd <= !we;
      addr <= a;
      wdata <= {24'h000000, d};
      do begin
         @(negedge mclk);
         w = waitreq;
         q = rdata;
         @(posedge mclk);
         n++;
      end while (w !== 1'b0 && n < 50);
      wr <= 1'b0;
      rd <= 1'b0;
      if (w !== 1'b0) chk("waitreq", 32'h0, {31'h0, w});
   endtask : bus
   task automatic wreg(input logic [3:0] a, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask : wreg
   task automatic rchk(input string nm, input logic [3:0] a, input logic [7:0] m,
         input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, a, 8'h00, q);
      chk(nm, {24'h000000, e}, q & {24'h000000, m});
   endtask : rchk
   task automatic waitbits(input int n);
      int k;
      k = 0;
      while (bits < n && k < 3000) begin
         @(negedge mclk);
         k++;
      end
      if (bits < n) chk("bits_seen", n, {27'h0, bits});
   endtask : waitbits
   task automatic idle();
      logic [31:0] q;
      int k;
      k = 0;
      do begin
         bus(1'b0, SSS_OFF_STAT, 8'h00, q);
         k++;
      end while (q[0] !== 1'b0 && k < 40);
      chk("idle_busy", 32'h0, {31'h0, q[0]});
   endtask : idle
   task automatic pulse_arm(input logic o, input logic [7:0] b);
      lsb <= o;
      txb <= b;
      arm <= 1'b1;
      @(posedge mclk);
      arm <= 1'b0;
   endtask : pulse_arm
   task automatic go_ext();
      ext_go <= 1'b1;
      @(posedge mclk);
      ext_go <= 1'b0;
   endtask : go_ext
   function automatic logic [7:0] cw(sss_row_type x, logic s);
      return {x.ck, x.md, x.ord, 1'b0, s};
   endfunction : cw
   function automatic logic [7:0] rev8(logic [7:0] x);
      for (int i = 0; i < 8; i++) rev8[i] = x[7 - i];
   endfunction : rev8
   initial begin
      {rd, wr, arm, ext_go, lsb} = 5'h00;
      reset = 1'b1;
      addr = 4'h0;
      wdata = 32'h00000000;
      txb = 8'h00;
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      foreach (rows[i]) begin
         r = rows[i];
         pulse_arm(r.ord, r.rx);
         base = irq_n;
         if (r.md != 2'h1) begin
            wreg(SSS_OFF_TXB, r.tx);
            rchk("tx_empty", SSS_OFF_STAT, 8'h04, 8'h00);
         end
         wreg(SSS_OFF_CTRL, cw(r, 1'b1));
         if (r.ck == SSS_CLK_EXTERNAL) go_ext();
         waitbits(1);
         rchk("busy_partial", SSS_OFF_STAT, 8'h03, 8'h03);
         chk("clk_drive", {31'h0, r.ck != SSS_CLK_EXTERNAL}, {31'h0, sck_oe});
         waitbits(8);
         wreg(SSS_OFF_CTRL, cw(r, 1'b0));
         idle();
         chk("so_idle", 32'h1, {31'h0, so});
         if (r.md != 2'h1) chk("so_byte", r.ord ? rev8(r.tx) : r.tx, cap[7:0]);
         if (r.md != 2'h0) rchk("rx_byte", SSS_OFF_RXB, 8'hFF, r.rx);
         rchk("rx_full", SSS_OFF_STAT, 8'h08, 8'h00);
         chk("irq", 32'h1, irq_n - base);
      end
      // internal: no byte no clock, then back to back bytes
      r = rows[0];
      pulse_arm(1'b0, 8'h00);
      wreg(SSS_OFF_CTRL, cw(r, 1'b1));
      repeat (40) @(posedge mclk);
      chk("no_clock", 32'h0, bits);
      t1 = cyc;
      wreg(SSS_OFF_TXB, 8'hA5);
      waitbits(1);
      chk("resume", 32'h1, (cyc - t1) <= 20);
      t1 = cyc;
      rchk("tx_empty", SSS_OFF_STAT, 8'h04, 8'h04);
      wreg(SSS_OFF_TXB, 8'h5A);
      waitbits(16);
      chk("gap", 32'd120, cyc - t1);
      chk("two_bytes", 32'hA55A, cap);
      wreg(SSS_OFF_CTRL, cw(r, 1'b0));
      idle();
      // external transmit underrun
      r = rows[5];
      pulse_arm(1'b0, 8'h00);
      base = irq_n;
      wreg(SSS_OFF_CTRL, cw(r, 1'b1));
      go_ext();
      waitbits(8);
      rchk("tx_err", SSS_OFF_STAT, 8'h10, 8'h10);
      chk("so_high", 32'hFF, cap[7:0]);
      chk("irq_err", 32'h1, irq_n != base);
      wreg(SSS_OFF_STAT, 8'h10);
      wreg(SSS_OFF_CTRL, cw(r, 1'b0));
      rchk("tx_err_kept", SSS_OFF_STAT, 8'h10, 8'h10);
      wreg(SSS_OFF_CTRL, 8'h02);
      rchk("inhibit_stat", SSS_OFF_STAT, 8'h3F, 8'h04);
      rchk("inhibit_ctrl", SSS_OFF_CTRL, 8'h03, 8'h00);
      // external receive overrun
      r = rows[6];
      pulse_arm(1'b0, 8'h3C);
      wreg(SSS_OFF_CTRL, cw(r, 1'b1));
      go_ext();
      waitbits(8);
      repeat (10) @(posedge mclk);
      pulse_arm(1'b0, 8'hC3);
      go_ext();
      waitbits(8);
      repeat (10) @(posedge mclk);
      rchk("rx_err", SSS_OFF_STAT, 8'h28, 8'h28);
      rchk("rx_kept", SSS_OFF_RXB, 8'hFF, 8'h3C);
      wreg(SSS_OFF_STAT, 8'h00);
      rchk("rx_err_clr", SSS_OFF_STAT, 8'h20, 8'h00);
      wreg(SSS_OFF_CTRL, 8'h02);
      rchk("inhibit_rx", SSS_OFF_RXB, 8'hFF, 8'h00);
      // second reset, then reset values and an unmapped place
      wreg(SSS_OFF_CTRL, 8'hFC);
      reset <= 1'b1;
      repeat (20) @(posedge mclk);
      reset <= 1'b0;
      rchk("ctrl_rst", SSS_OFF_CTRL, 8'hFF, SSS_CTRL_RESET);
      rchk("stat_rst", SSS_OFF_STAT, 8'hFF, 8'h04);
      rchk("txb_read", SSS_OFF_TXB, 8'hFF, 8'h00);
      wreg(4'h2, 8'hFF);
      rchk("unmapped", 4'h2, 8'hFF, 8'h00);
      end_sim();
   end
endmodule : tb_top
